/* File: verilog/icr_pkg.sv */
// Purpose: Shared constants and types for the indexed configuration bank.
// Assumes: ISA-style 10-bit I/O port decode and 8-bit data.
// Notes: Register numbers, defaults and bit positions live here only.

package icr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and ports
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NUM_CR = 16;
  localparam int IDX_W = 4;
  localparam logic [ADDR_W-1:0] INDEX_PORT = 10'h3F0;
  localparam logic [ADDR_W-1:0] DATA_PORT = 10'h3F1;

  // ----------------------------------------------------------------
  // Key values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] KEY_ENTER = 8'h55;
  localparam logic [DATA_W-1:0] KEY_EXIT = 8'hAA;

  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] CR_CORE_FUNC = 4'h0;
  localparam logic [IDX_W-1:0] CR_LOCK_PP = 4'h1;
  localparam logic [IDX_W-1:0] CR_CHIP_ID = 4'hD;
  localparam logic [IDX_W-1:0] CR_CHIP_REV = 4'hE;

  // ----------------------------------------------------------------
  // Power-up defaults, index 0 in the low byte
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_CORE_FUNC = 8'h3B;
  localparam logic [DATA_W-1:0] RST_LOCK_PP = 8'h9F;
  localparam logic [DATA_W-1:0] RST_SERIAL = 8'hDC;
  localparam logic [DATA_W-1:0] RST_FLOPPY_OPT = 8'h78;
  localparam logic [DATA_W-1:0] RST_DRIVE_TYPE = 8'hFF;
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
  localparam logic [NUM_CR-1:0][DATA_W-1:0] CR_RESET = {
    RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
    RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
    RST_ZERO, RST_DRIVE_TYPE, RST_ZERO, RST_ZERO,
    RST_FLOPPY_OPT, RST_SERIAL, RST_LOCK_PP, RST_CORE_FUNC};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_DISK_EN = 0;
  localparam int BIT_DISK_TYPE = 1;
  localparam int BIT_RSVD_TWO = 2;
  localparam int BIT_FLOPPY_PWR = 3;
  localparam int BIT_FLOPPY_EN = 4;
  localparam int BIT_OSC_LO = 5;
  localparam int BIT_OSC_HI = 6;
  localparam int BIT_VALID = 7;
  localparam int BIT_LOCK = 7;

  localparam logic [1:0] OSC_ALWAYS_ON = 2'h0;
  localparam logic [1:0] OSC_ALWAYS_OFF = 2'h3;

  // ----------------------------------------------------------------
  // Timing: two flip-flops on every bus and power-good pin
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ICR_LOCKED,
    ICR_KEY_ONE,
    ICR_CONFIG
  } icr_key_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic wr_n;
    logic rd_n;
  } icr_io_pins_s;

  typedef struct packed {
    logic disk_if_enable;
    logic disk_if_type_select;
    logic floppy_power_bit;
    logic floppy_enable_bit;
    logic osc_run;
    logic baud_clock_run;
    logic config_valid_flag;
  } icr_func_ctrl_s;

endpackage : icr_pkg

/* File: verilog/icr_pin_sync.sv */
// Purpose: Two-stage synchroniser for a group of pins.
// Assumes: Pins change slowly compared with the clock.
// Notes: Only the second stage may be read outside this module.

`timescale 1ns/100ps

module icr_pin_sync
  import icr_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule : icr_pin_sync

/* File: verilog/icr_key_seq.sv */
// Purpose: Unlock key sequencer that opens and closes configuration mode.
// Assumes: One write pulse per host write, address and data held with it.
// Notes: Reads never disturb the sequence; only writes count.

`timescale 1ns/100ps

module icr_key_seq
  import icr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_pulse,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  output logic config_mode,
  output logic mode_entered
);

  icr_key_state_e state_ff;
  icr_key_state_e nxt_state;
  logic entered_ff;
  logic nxt_entered;
  logic to_index;

  always_comb begin
    to_index = (wr_addr == INDEX_PORT);
    nxt_state = state_ff;
    nxt_entered = 1'b0;
    if (wr_pulse) begin
      case (state_ff)
        ICR_LOCKED: begin
          if (to_index && wr_data == KEY_ENTER) begin
            nxt_state = ICR_KEY_ONE; // [RQ1]
          end
        end
        ICR_KEY_ONE: begin
          // Any other write, to any port, throws the attempt away
          if (to_index && wr_data == KEY_ENTER) begin
            nxt_state = ICR_CONFIG; // [RQ1]
            nxt_entered = 1'b1;
          end else begin
            nxt_state = ICR_LOCKED; // [RQ1]
          end
        end
        ICR_CONFIG: begin
          if (to_index && wr_data == KEY_EXIT) begin
            nxt_state = ICR_LOCKED; // [RQ2]
          end
        end
        default: begin
          nxt_state = ICR_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= ICR_LOCKED;
      entered_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      entered_ff <= nxt_entered;
    end
  end

  assign config_mode = (state_ff == ICR_CONFIG);
  assign mode_entered = entered_ff;

endmodule : icr_key_seq

/* File: verilog/icr_config_bank.sv */
// Purpose: Indexed configuration register bank behind two I/O ports.
// Assumes: ISA-style pins, synchronised here; 250 MHz clock.
// Notes: Bank contents follow por_n only; rst_n touches the lock bit.
//
// What this block does
// [RQ1] Two back-to-back 55h index writes unlock
// [RQ2] Writing AAh to index port locks
// [RQ3] One index plus sixteen data registers
// [RQ4] Index loaded by writing port 3F0h
// [RQ5] Data port 3F1h reaches indexed register
// [RQ6] Index only in config mode, load first
// [RQ7] Defaults at power-up, kept over reset
// [RQ8] Register 0 at index 0, default 3Bh
// [RQ9] Bit 0 enables disk interface decode
// [RQ10] Bit 1 selects AT or XT decode
// [RQ11] Bit 2 reserved, software writes zero
// [RQ12] Bit 3 keeps floppy fully powered
// [RQ13] Bit 4 enables the floppy controller
// [RQ14] Bits 6:5 pick oscillator and baud run
// [RQ15] Bit 7 plain software valid flag
// [RQ16] Lock bit cleared blocks bank until reset
// [RQ17] Outside config mode nothing changes

`timescale 1ns/100ps

module icr_config_bank
  import icr_pkg::*;
#(
  parameter logic [DATA_W-1:0] CHIP_ID_VAL = 8'h5A,  // Arbitrary value
  parameter logic [DATA_W-1:0] CHIP_REV_VAL = 8'h03  // Arbitrary value
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic por_n,
  input wire icr_io_pins_s io_pins,
  input wire logic power_good_input,
  output logic [DATA_W-1:0] io_data_out,
  output logic io_data_oe,
  output logic config_mode,
  output logic config_lock_bit,
  output icr_func_ctrl_s func_ctrl,
  output logic [NUM_CR-1:0][DATA_W-1:0] config_regs
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hits_port(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] port);
    hits_port = (addr == port);
  endfunction : hits_port

  function automatic logic osc_enabled(input logic [1:0] mode,
                                       input logic pgood);
    case (mode)
      OSC_ALWAYS_ON: osc_enabled = 1'b1;
      OSC_ALWAYS_OFF: osc_enabled = 1'b0;
      default: osc_enabled = pgood;
    endcase
  endfunction : osc_enabled

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = $bits(icr_io_pins_s);
  localparam logic [PIN_W-1:0] PIN_INIT = {{(PIN_W - 2){1'b0}}, 2'b11};

  icr_io_pins_s pins_sync;
  logic pgood_sync;

  icr_pin_sync #(
    .WIDTH(PIN_W),
    .INIT(PIN_INIT)
  ) u_io_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(io_pins),
    .sync_out(pins_sync)
  );

  icr_pin_sync #(
    .WIDTH(1),
    .INIT(1'b0)
  ) u_pgood_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(power_good_input),
    .sync_out(pgood_sync)
  );

  // ----------------------------------------------------------------
  // Write strobe edge
  // ----------------------------------------------------------------
  // A host write is one pulse on the falling edge of the synced strobe,
  // so a long ISA cycle still counts as exactly one write.
  logic wr_n_dly_ff;
  logic nxt_wr_n_dly;
  logic wr_pulse;

  always_comb begin
    nxt_wr_n_dly = pins_sync.wr_n;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_n_dly_ff <= 1'b1;
    end else begin
      wr_n_dly_ff <= nxt_wr_n_dly;
    end
  end

  assign wr_pulse = wr_n_dly_ff && !pins_sync.wr_n;

  // ----------------------------------------------------------------
  // Key sequencer
  // ----------------------------------------------------------------
  logic mode_entered;

  icr_key_seq u_key_seq (
    .clock(clock),
    .rst_n(rst_n),
    .wr_pulse(wr_pulse),
    .wr_addr(pins_sync.addr),
    .wr_data(pins_sync.data),
    .config_mode(config_mode),
    .mode_entered(mode_entered)
  );

  // ----------------------------------------------------------------
  // Index register
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] index_ff;
  logic index_loaded_ff;
  logic [DATA_W-1:0] nxt_index;
  logic nxt_index_loaded;
  logic index_wr;

  always_comb begin
    index_wr = wr_pulse && config_mode &&
               hits_port(pins_sync.addr, INDEX_PORT) &&
               pins_sync.data != KEY_EXIT; // [RQ4] [RQ17]
    nxt_index = index_ff;
    nxt_index_loaded = index_loaded_ff;
    if (mode_entered) begin
      nxt_index_loaded = 1'b0; // [RQ6]
    end
    if (index_wr) begin
      nxt_index = pins_sync.data; // [RQ4]
      nxt_index_loaded = 1'b1; // [RQ6]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      index_ff <= 8'h00;
      index_loaded_ff <= 1'b0;
    end else begin
      index_ff <= nxt_index;
      index_loaded_ff <= nxt_index_loaded;
    end
  end

  // ----------------------------------------------------------------
  // Data register access decode
  // ----------------------------------------------------------------
  logic [NUM_CR-1:0][DATA_W-1:0] cr_ff;
  logic [NUM_CR-1:0][DATA_W-1:0] nxt_cr;
  logic [IDX_W-1:0] sel;
  logic sel_in_range;
  logic access_ok;
  logic data_wr;
  logic data_rd;
  logic sel_read_only;

  always_comb begin
    sel = index_ff[IDX_W-1:0];
    sel_in_range = (index_ff[DATA_W-1:IDX_W] == '0); // [RQ3]
    // Lock bit low shuts the whole bank until a reset restores it
    access_ok = config_mode && index_loaded_ff && sel_in_range &&
                cr_ff[CR_LOCK_PP][BIT_LOCK]; // [RQ6] [RQ16] [RQ17]
    sel_read_only = (sel == CR_CHIP_ID) || (sel == CR_CHIP_REV);
    data_wr = wr_pulse && access_ok && !sel_read_only &&
              hits_port(pins_sync.addr, DATA_PORT); // [RQ5]
    data_rd = !pins_sync.rd_n && access_ok &&
              hits_port(pins_sync.addr, DATA_PORT); // [RQ5]
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cr = cr_ff;
    if (data_wr) begin
      // Bit 2 of register 0 is stored as written; software keeps it zero
      nxt_cr[sel] = pins_sync.data; // [RQ5] [RQ8] [RQ11] [RQ15]
    end
    if (!rst_n) begin
      nxt_cr[CR_LOCK_PP][BIT_LOCK] = 1'b1; // [RQ16]
    end
  end

  // Only por_n restores defaults; rst_n only sets the lock bit again
  always_ff @(posedge clock) begin
    if (!por_n) begin
      cr_ff <= CR_RESET; // [RQ7] [RQ8]
    end else begin
      cr_ff <= nxt_cr; // [RQ7]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_data_ff;
  logic rd_oe_ff;
  logic [DATA_W-1:0] nxt_rd_data;
  logic nxt_rd_oe;

  always_comb begin
    case (sel)
      CR_CHIP_ID: nxt_rd_data = CHIP_ID_VAL;
      CR_CHIP_REV: nxt_rd_data = CHIP_REV_VAL;
      default: nxt_rd_data = cr_ff[sel]; // [RQ5]
    endcase
    if (!data_rd) begin
      nxt_rd_data = 8'h00;
    end
    nxt_rd_oe = data_rd;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
      rd_oe_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_oe_ff <= nxt_rd_oe;
    end
  end

  assign io_data_out = rd_data_ff;
  assign io_data_oe = rd_oe_ff;

  // ----------------------------------------------------------------
  // Function controls from register 0
  // ----------------------------------------------------------------
  icr_func_ctrl_s func_ff;
  icr_func_ctrl_s nxt_func;
  logic osc_on;

  always_comb begin
    osc_on = osc_enabled(cr_ff[CR_CORE_FUNC][BIT_OSC_HI:BIT_OSC_LO],
                         pgood_sync); // [RQ14]
    nxt_func.disk_if_enable =
      cr_ff[CR_CORE_FUNC][BIT_DISK_EN]; // [RQ9]
    nxt_func.disk_if_type_select =
      cr_ff[CR_CORE_FUNC][BIT_DISK_TYPE]; // [RQ10]
    nxt_func.floppy_power_bit =
      cr_ff[CR_CORE_FUNC][BIT_FLOPPY_PWR]; // [RQ12]
    nxt_func.floppy_enable_bit =
      cr_ff[CR_CORE_FUNC][BIT_FLOPPY_EN]; // [RQ13]
    nxt_func.osc_run = osc_on; // [RQ14]
    nxt_func.baud_clock_run = osc_on; // [RQ14]
    nxt_func.config_valid_flag =
      cr_ff[CR_CORE_FUNC][BIT_VALID]; // [RQ15]
  end

  // Registered one cycle so outputs see no decode glitches
  always_ff @(posedge clock) begin
    if (!por_n) begin
      func_ff <= '0;
    end else begin
      func_ff <= nxt_func;
    end
  end

  assign func_ctrl = func_ff;
  assign config_lock_bit = cr_ff[CR_LOCK_PP][BIT_LOCK];
  assign config_regs = cr_ff;

endmodule : icr_config_bank

/* File: sim/icr_host_model.sv */
// Purpose: ISA host model issuing port writes and reads.
// Assumes: Three cycles of setup and hold around each strobe.
// Notes: Data lines show the inverse byte once the hold has run out.

`timescale 1ns/100ps

module icr_host_model
  import icr_pkg::*;
(
  input wire logic clock,
  output icr_io_pins_s io_pins,
  input wire logic [DATA_W-1:0] io_data_out,
  input wire logic io_data_oe
);
  // ----------------------------------------------------------------
  // Port cycles
  // ----------------------------------------------------------------
  initial begin
    io_pins = '{addr: INDEX_PORT, data: 8'h00, wr_n: 1'b1, rd_n: 1'b1};
  end

  task automatic io_write(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
    io_pins.addr <= a;
    io_pins.data <= d;
    repeat (3) @(posedge clock);
    io_pins.wr_n <= 1'b0;
    repeat (3) @(posedge clock);
    io_pins.wr_n <= 1'b1;
    repeat (3) @(posedge clock);
    io_pins.data <= ~d;
    repeat (2) @(posedge clock);
  endtask : io_write

  // Gives up after eight edges, so a refused read just reports no drive
  task automatic io_read(input logic [ADDR_W-1:0] a,
                         output logic [DATA_W-1:0] d, output logic seen);
    int n;
    io_pins.addr <= a;
    repeat (3) @(posedge clock);
    io_pins.rd_n <= 1'b0;
    n = 0;
    seen = 1'b0;
    while (n < 8 && !seen) begin
      @(posedge clock);
      seen = (io_data_oe === 1'b1);
      n++;
    end
    d = io_data_out;
    io_pins.rd_n <= 1'b1;
    repeat (5) @(posedge clock);
  endtask : io_read
endmodule : icr_host_model

/* File: sim/icr_config_bank_checker.sv */
// Purpose: Port-level checks for the configuration bank.
// Assumes: Sees only the top module ports.
// Notes: Attached by bind below.

`timescale 1ns/100ps

module icr_config_bank_checker
  import icr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic por_n,
  input wire icr_io_pins_s io_pins,
  input wire logic power_good_input,
  input wire logic [DATA_W-1:0] io_data_out,
  input wire logic io_data_oe,
  input wire logic config_mode,
  input wire logic config_lock_bit,
  input wire icr_func_ctrl_s func_ctrl,
  input wire logic [NUM_CR-1:0][DATA_W-1:0] config_regs
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  wire logic [4:0] r0_bits = {config_regs[0][7], config_regs[0][4],
    config_regs[0][3], config_regs[0][1], config_regs[0][0]};
  wire logic [4:0] fc_bits = {func_ctrl.config_valid_flag,
    func_ctrl.floppy_enable_bit, func_ctrl.floppy_power_bit,
    func_ctrl.disk_if_type_select, func_ctrl.disk_if_enable};

  sequence rd_idle_s;
    io_pins.rd_n [*5];
  endsequence

  mode_reset_a: assert property (@(posedge clock)
    disable iff (!por_n)
    !rst_n |=> !config_mode && !io_data_oe && config_lock_bit)
    else $error("reset left mode, drive or lock wrong");
  data_zero_a: assert property (@(posedge clock)
    disable iff (!rst_n)
    !io_data_oe |-> io_data_out == 8'h00)
    else $error("read data not zero while idle");
  oe_allowed_a: assert property (@(posedge clock)
    disable iff (!rst_n)
    $rose(io_data_oe) |-> config_mode && config_lock_bit)
    else $error("data driven outside an allowed access");
  rd_idle_a: assert property (@(posedge clock)
    disable iff (!rst_n)
    rd_idle_s |-> !io_data_oe)
    else $error("data still driven after read ended");
  func_follow_a: assert property (
    @(posedge clock)
    disable iff (!por_n || !rst_n) 1'b1 |=> fc_bits == $past(r0_bits))
    else $error("function controls do not follow register 0");
  osc_on_a: assert property (@(posedge clock)
    disable iff (!por_n || !rst_n)
    config_regs[0][6:5] == OSC_ALWAYS_ON |=>
    func_ctrl.osc_run && func_ctrl.baud_clock_run)
    else $error("clocks stopped in always-on mode");
  osc_off_a: assert property (@(posedge clock)
    disable iff (!por_n || !rst_n)
    config_regs[0][6:5] == OSC_ALWAYS_OFF |=>
    !func_ctrl.osc_run && !func_ctrl.baud_clock_run)
    else $error("clocks running in stopped mode");
  // Gated modes follow the pin three edges late, through the synchroniser
  osc_pgood_a: assert property (@(posedge clock)
    disable iff (!por_n || !rst_n)
    $past(rst_n) && $past(rst_n, 2) &&
    (config_regs[0][6:5] == 2'h1 || config_regs[0][6:5] == 2'h2) |=>
    func_ctrl.osc_run == $past(power_good_input, 3) &&
    func_ctrl.baud_clock_run == $past(power_good_input, 3))
    else $error("clocks do not follow power good in gated mode");
  locked_hold_a: assert property (@(posedge clock)
    disable iff (!por_n || !rst_n) !config_mode |=> $stable(config_regs))
    else $error("bank changed outside configuration mode");
  lock_sticky_a: assert property (@(posedge clock)
    disable iff (!por_n || !rst_n)
    !config_lock_bit |=> !config_lock_bit && $stable(config_regs))
    else $error("bank changed or unlocked while locked");
endmodule : icr_config_bank_checker

bind icr_config_bank icr_config_bank_checker chk_u (
  .clock(clock), .rst_n(rst_n), .por_n(por_n), .io_pins(io_pins),
  .power_good_input(power_good_input), .io_data_out(io_data_out),
  .io_data_oe(io_data_oe), .config_mode(config_mode),
  .config_lock_bit(config_lock_bit), .func_ctrl(func_ctrl),
  .config_regs(config_regs));

/* File: sim/icr_config_bank_tb.sv */
// Purpose: Self-checking bench for the configuration bank.
// Assumes: Host model performs all port cycles.
// Notes: Identity parameters are set to arbitrary values.

`timescale 1ns/100ps

module icr_config_bank_tb
  import icr_pkg::*;
;
  localparam logic [DATA_W-1:0] ID_VAL = 8'h4C; // Arbitrary value
  localparam logic [DATA_W-1:0] REV_VAL = 8'h02; // Arbitrary value
  localparam logic [DATA_W-1:0] DEF [NUM_CR] = '{
    8'h3B, 8'h9F, 8'hDC, 8'h78, 8'h00, 8'h00, 8'hFF, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, ID_VAL, REV_VAL, 8'h00};
  logic clock, rst_n, por_n, power_good_input;
  icr_io_pins_s io_pins;
  logic [DATA_W-1:0] io_data_out, rd_val;
  logic io_data_oe, config_mode, config_lock_bit, rd_ok;
  icr_func_ctrl_s func_ctrl;
  logic [NUM_CR-1:0][DATA_W-1:0] config_regs;
  int n_fail, num_checks;

  icr_config_bank #(.CHIP_ID_VAL(ID_VAL), .CHIP_REV_VAL(REV_VAL)) dut_u (
    .clock(clock), .rst_n(rst_n), .por_n(por_n), .io_pins(io_pins),
    .power_good_input(power_good_input), .io_data_out(io_data_out),
    .io_data_oe(io_data_oe), .config_mode(config_mode),
    .config_lock_bit(config_lock_bit), .func_ctrl(func_ctrl),
    .config_regs(config_regs));
  icr_host_model host_u (.clock(clock), .io_pins(io_pins),
    .io_data_out(io_data_out), .io_data_oe(io_data_oe));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic enter();
    host_u.io_write(INDEX_PORT, KEY_ENTER);
    host_u.io_write(INDEX_PORT, KEY_ENTER);
  endtask : enter

  task automatic cfg_wr(input logic [3:0] i, input logic [7:0] d);
    host_u.io_write(INDEX_PORT, {4'h0, i});
    host_u.io_write(DATA_PORT, d);
  endtask : cfg_wr

  task automatic cfg_rd(input logic [3:0] i, input logic [7:0] e,
                        input logic ok);
    host_u.io_write(INDEX_PORT, {4'h0, i});
    host_u.io_read(DATA_PORT, rd_val, rd_ok);
    chk({7'h0, rd_ok}, {7'h0, ok});
    if (ok)
      chk(rd_val, e);
  endtask : cfg_rd

  task automatic pulse_reset(input logic por);
    rst_n <= 1'b0;
    por_n <= ~por;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : pulse_reset

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_defaults();
    enter();
    chk({7'h0, config_mode}, 8'h01);
    chk({1'b0, func_ctrl}, 8'h7E);
    for (int i = 0; i < NUM_CR; i++)
      cfg_rd(i[3:0], DEF[i], 1'b1);
  endtask : test_defaults

  // Stray writes outside the mode, a broken key, then a read with no index
  task automatic test_key_cancel();
    host_u.io_write(INDEX_PORT, KEY_EXIT);
    chk({7'h0, config_mode}, 8'h00);
    host_u.io_write(INDEX_PORT, 8'h02);
    host_u.io_write(DATA_PORT, 8'h11);
    chk(config_regs[2], DEF[2]);
    host_u.io_write(INDEX_PORT, KEY_ENTER);
    host_u.io_write(DATA_PORT, KEY_ENTER);
    host_u.io_write(INDEX_PORT, KEY_ENTER);
    chk({7'h0, config_mode}, 8'h00);
    host_u.io_write(INDEX_PORT, KEY_ENTER);
    chk({7'h0, config_mode}, 8'h01);
    host_u.io_read(DATA_PORT, rd_val, rd_ok);
    chk({7'h0, rd_ok}, 8'h00);
  endtask : test_key_cancel

  task automatic test_func_bits();
    logic [7:0] v;
    logic run;
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 2; p++) begin
        power_good_input <= p[0];
        v = {p[0], m[1:0], 1'b0, m[0], 1'b0, p[0], m[1]};
        cfg_wr(4'h0, v);
        repeat (2) @(posedge clock);
        run = (m == 0) || (m != 3 && p[0]);
        chk(config_regs[0], v);
        chk({1'b0, func_ctrl}, {1'b0, v[0], v[1], v[3], v[4], run, run,
          v[7]});
      end
    end
  endtask : test_func_bits

  task automatic test_reset_keep();
    cfg_wr(4'h2, 8'h5A);
    pulse_reset(1'b0);
    chk({7'h0, config_mode}, 8'h00);
    enter();
    cfg_rd(4'h2, 8'h5A, 1'b1);
    pulse_reset(1'b1);
    chk(config_regs[2], DEF[2]);
    chk(config_regs[0], DEF[0]);
  endtask : test_reset_keep

  task automatic test_lock();
    enter();
    cfg_wr(4'h1, 8'h1F);
    chk({7'h0, config_lock_bit}, 8'h00);
    cfg_wr(4'h0, 8'h00);
    chk(config_regs[0], DEF[0]);
    cfg_rd(4'h0, 8'h00, 1'b0);
    pulse_reset(1'b0);
    chk({7'h0, config_lock_bit}, 8'h01);
  endtask : test_lock

  initial begin
    n_fail = 0;
    num_checks = 0;
    rst_n = 1'b0;
    por_n = 1'b0;
    power_good_input = 1'b1;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clock);
    test_defaults();
    test_key_cancel();
    test_func_bits();
    test_reset_keep();
    test_lock();
    report_and_stop();
  end

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    report_and_stop();
  end
endmodule : icr_config_bank_tb
